// ### verilog/uart_flags_regs.svh
// register offsets, field positions, reset values and run lengths
// of the serial status flag block; included by the flag block and its checker
`ifndef UART_FLAGS_REGS_SVH
`define UART_FLAGS_REGS_SVH

// byte addresses on the register bus
`define UF_STATUS_OFFSET 8'h04
`define UF_CONTROL_OFFSET 8'h08
`define UF_DATA_LOW_OFFSET 8'h0c

// status flag positions
`define UF_TX_EMPTY_BIT 7
`define UF_TX_DONE_BIT 6
`define UF_RX_FULL_BIT 5
`define UF_IDLE_BIT 4
`define UF_OVERRUN_BIT 3
`define UF_NOISE_BIT 2
`define UF_FRAME_ERR_BIT 1
`define UF_PARITY_ERR_BIT 0

// control field positions
`define UF_TX_EMPTY_IRQ_EN_BIT 7
`define UF_TX_DONE_IRQ_EN_BIT 6
`define UF_RECEIVE_INT_EN_BIT 5
`define UF_LINE_QUIET_IRQ_EN_BIT 4
`define UF_NINE_BIT_BIT 3
`define UF_PARITY_CHECK_ON_BIT 2
`define UF_PARITY_TYPE_BIT 1
`define UF_STANDBY_BIT 0

// reset values
`define UF_STATUS_RESET 8'hc0
`define UF_CONTROL_RESET 8'h00

// idle line run lengths in bit times
`define UF_IDLE_RUN_8BIT 4'h a
`define UF_IDLE_RUN_9BIT 4'h b

`endif

// ### verilog/uart_flags_pkg.sv
// types shared by the status flag block and its bench
// assumes the constants header sits beside it
package uart_flags_pkg;

   // one received frame as handed over by the receive shifter
   typedef struct packed {
      logic [7:0] data;
      logic bit8;
      logic parity_bit;
      logic noise;
      logic stop_bad;
   } rx_event_t;

   // control register layout, msb first
   typedef struct packed {
      logic tx_empty_irq_en;
      logic tx_done_irq_en;
      logic receive_int_en;
      logic line_quiet_irq_en;
      logic nine_bit;
      logic parity_check_on;
      logic parity_type_select;
      logic receiver_standby_bit;
   } control_t;

endpackage

// ### verilog/flag_cell.sv
// one status flag with read-then-access clearing
// assumes events arrive on core_clk from the same domain
module flag_cell #(
   parameter bit CLEAR_WINS = 1'b0,
   parameter bit RESET_VAL = 1'b0
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic set,
   input wire logic clr_auto,
   input wire logic rd_status,
   input wire logic seen,
   input wire logic data_access,
   output logic flag
);

   logic armed;
   logic clear_now;

   // clearing needs an armed read first, or an automatic clear
   assign clear_now = (armed & data_access) | clr_auto;

   // armed only by a status read that returned the flag set
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         armed <= 1'b0;
      end else if (rd_status) begin
         armed <= seen;
      end else if (clear_now) begin
         armed <= 1'b0;
      end
   end

   // the flag itself; priority picked per instance
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= RESET_VAL;
      end else if (CLEAR_WINS && clear_now) begin
         flag <= 1'b0;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clear_now) begin
         flag <= 1'b0;
      end
   end

endmodule

// ### verilog/idle_run_counter.sv
// counts bit times of continuous mark on the receive line
// assumes line_high is already synchronised and bit_tick is one cycle wide
module idle_run_counter (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic line_high,
   input wire logic bit_tick,
   input wire logic [3:0] run_len,
   output logic idle_seen
);

   logic [3:0] run;

   // any space restarts the run; count saturates at the run length
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         run <= 4'h0;
      end else if (!line_high) begin
         run <= 4'h0;
      end else if (bit_tick && run != run_len) begin
         run <= run + 4'h1;
      end
   end

   // one pulse as the run completes
   assign idle_seen = line_high & bit_tick & (run == run_len - 4'h1);

endmodule

// ### verilog/uart_status_flags_one.sv
// first status register of an asynchronous serial port, with its flags
// assumes transmit and receive shifters on core_clk and an apb master
//
// What this block does
// - clear is status read, then data access
// - transmit empty sets when shifter loads
// - armed read plus data write clears empty
// - done low while sending, high when idle
// - done clears by read-write or queued send
// - done: simultaneous set and clear clears
// - receive full sets on transfer, read clears
// - idle after 10 or 11 marks
// - idle rearms only after a received frame
// - no idle flag while receiver stands by
// - armed read plus data read clears idle
// - overrun keeps old data, drops new
// - overrun clears by read then data read
// - noise sets with full, not on overrun
// - stop error sets, blocks further reception
// - parity mismatch sets parity error flag
// - error flags clear by read then data read
// - writes to status register are ignored
// - all flags readable; noise, framing, parity flags feed no interrupt
// - each interrupt source gated by enable
// - word length bit selects nine bits
//
// Decided for this implementation: the APB slave port.
`include "uart_flags_regs.svh"

module uart_status_flags_one (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_line,
   input wire logic bit_tick,
   input wire uart_flags_pkg::rx_event_t rx_frame,
   input wire logic rx_frame_valid,
   output logic rx_accept,
   input wire logic tx_load,
   input wire logic tx_busy,
   input wire logic tx_queued,
   output logic [7:0] tx_byte,
   output logic tx_full,
   output logic irq
);

   logic rst_meta_n;
   logic rst_sync_n;
   logic line_meta;
   logic line_sync;

   uart_flags_pkg::control_t control;
   logic [7:0] flags;
   logic [7:0] status_seen;
   logic [7:0] rx_byte;
   logic rx_bit8;
   logic idle_armed;
   logic setup_unmapped;

   logic setup;
   logic access;
   logic status_rd;
   logic data_rd;
   logic data_wr;
   logic control_wr;
   logic rx_take;
   logic rx_over;
   logic parity_bad;
   logic idle_seen;
   logic idle_set;
   logic done_set;
   logic done_auto;
   logic [3:0] idle_run;
   logic [7:0] next_rdata;
   logic next_unmapped;

   // reset release through two flops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // receive pin into the clock domain, idle high
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         line_meta <= 1'b1;
         line_sync <= 1'b1;
      end else begin
         line_meta <= rx_line;
         line_sync <= line_meta;
      end
   end

   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------

   // phases of an apb transfer; the slave never stalls
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign pready = 1'b1;

   // access strobes per register
   assign status_rd = access & ~pwrite & (paddr == `UF_STATUS_OFFSET);
   assign data_rd = access & ~pwrite & (paddr == `UF_DATA_LOW_OFFSET);
   assign data_wr = access & pwrite & (paddr == `UF_DATA_LOW_OFFSET);
   assign control_wr = access & pwrite & (paddr == `UF_CONTROL_OFFSET);

   // read mux, sampled in the setup cycle
   always_comb begin
      next_rdata = 8'h00;
      next_unmapped = 1'b0;
      case (paddr)
         `UF_STATUS_OFFSET: begin
            next_rdata = flags;
         end
         `UF_CONTROL_OFFSET: begin
            next_rdata = control;
         end
         `UF_DATA_LOW_OFFSET: begin
            next_rdata = rx_byte;
         end
         default: begin
            next_unmapped = 1'b1;
         end
      endcase
   end

   // read data and error held through the access phase
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         prdata <= 32'h0000_0000;
         setup_unmapped <= 1'b0;
      end else if (setup) begin
         prdata <= {24'h00_0000, pwrite ? 8'h00 : next_rdata};
         setup_unmapped <= next_unmapped;
      end
   end

   // error answer only on an unmapped address
   assign pslverr = access & setup_unmapped;

   // the flags exactly as returned to the reader
   assign status_seen = prdata[7:0];

   // ------------------------------------------------------------------
   // control and data registers
   // ------------------------------------------------------------------

   // interrupt enables and receive options; status writes fall through
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         control <= `UF_CONTROL_RESET;
      end else if (control_wr) begin
         control <= pwdata[7:0];
      end
   end

   // transmit byte taken from a data write
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tx_byte <= 8'h00;
      end else if (data_wr) begin
         tx_byte <= pwdata[7:0];
      end
   end

   // a waiting byte is the inverse of the empty flag
   assign tx_full = ~flags[`UF_TX_EMPTY_BIT];

   // receive data only moves when the holding register is free
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rx_byte <= 8'h00;
         rx_bit8 <= 1'b0;
      end else if (rx_take) begin
         rx_byte <= rx_frame.data;
         rx_bit8 <= rx_frame.bit8;
      end
   end

   // ------------------------------------------------------------------
   // receive events
   // ------------------------------------------------------------------

   // a framing error holds the receiver off until cleared
   assign rx_accept = ~flags[`UF_FRAME_ERR_BIT];

   // an accepted new frame either lands or overruns; while blocked it is dropped
   assign rx_take = rx_frame_valid & rx_accept & ~flags[`UF_RX_FULL_BIT];
   assign rx_over = rx_frame_valid & rx_accept & flags[`UF_RX_FULL_BIT];

   // parity over data, ninth bit and parity bit against the chosen type
   assign parity_bad = ((^rx_frame.data) ^ (control.nine_bit & rx_frame.bit8)
                        ^ rx_frame.parity_bit) != control.parity_type_select;

   // idle run length follows the word length
   assign idle_run = control.nine_bit ? `UF_IDLE_RUN_9BIT : `UF_IDLE_RUN_8BIT;

   idle_run_counter u_idle (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .line_high(line_sync),
      .bit_tick(bit_tick),
      .run_len(idle_run),
      .idle_seen(idle_seen)
   );

   // idle reports once, then waits for a received frame
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         idle_armed <= 1'b1;
      end else if (rx_take) begin
         idle_armed <= 1'b1;
      end else if (flags[`UF_IDLE_BIT]) begin
         idle_armed <= 1'b0;
      end
   end

   // standby hides the idle condition
   assign idle_set = idle_seen & idle_armed & ~control.receiver_standby_bit;

   // ------------------------------------------------------------------
   // transmit events
   // ------------------------------------------------------------------

   // done rises once empty and nothing is on the line or queued
   assign done_set = flags[`UF_TX_EMPTY_BIT] & ~tx_busy & ~tx_queued;
   // done drops while sending or once anything is queued
   assign done_auto = tx_busy | tx_queued | data_wr;

   // ------------------------------------------------------------------
   // the flags
   // ------------------------------------------------------------------

   // transmit empty: set by the shifter load, cleared by a data write
   flag_cell #(.CLEAR_WINS(1'b0), .RESET_VAL(1'(`UF_STATUS_RESET >> `UF_TX_EMPTY_BIT))) u_empty (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .set(tx_load),
      .clr_auto(1'b0),
      .rd_status(status_rd),
      .seen(status_seen[`UF_TX_EMPTY_BIT]),
      .data_access(data_wr),
      .flag(flags[`UF_TX_EMPTY_BIT])
   );

   // transmit done: clearing has priority over setting
   flag_cell #(.CLEAR_WINS(1'b1), .RESET_VAL(1'(`UF_STATUS_RESET >> `UF_TX_DONE_BIT))) u_done (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .set(done_set),
      .clr_auto(done_auto),
      .rd_status(status_rd),
      .seen(status_seen[`UF_TX_DONE_BIT]),
      .data_access(data_wr),
      .flag(flags[`UF_TX_DONE_BIT])
   );

   // receive full
   flag_cell #(.CLEAR_WINS(1'b0), .RESET_VAL(1'b0)) u_rx_full (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .set(rx_take),
      .clr_auto(1'b0),
      .rd_status(status_rd),
      .seen(status_seen[`UF_RX_FULL_BIT]),
      .data_access(data_rd),
      .flag(flags[`UF_RX_FULL_BIT])
   );

   // idle line
   flag_cell #(.CLEAR_WINS(1'b0), .RESET_VAL(1'b0)) u_idle_flag (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .set(idle_set),
      .clr_auto(1'b0),
      .rd_status(status_rd),
      .seen(status_seen[`UF_IDLE_BIT]),
      .data_access(data_rd),
      .flag(flags[`UF_IDLE_BIT])
   );

   // overrun may outlive receive full and then needs its own data read
   flag_cell #(.CLEAR_WINS(1'b0), .RESET_VAL(1'b0)) u_overrun (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .set(rx_over),
      .clr_auto(1'b0),
      .rd_status(status_rd),
      .seen(status_seen[`UF_OVERRUN_BIT]),
      .data_access(data_rd),
      .flag(flags[`UF_OVERRUN_BIT])
   );

   // noise, only alongside a frame that lands
   flag_cell #(.CLEAR_WINS(1'b0), .RESET_VAL(1'b0)) u_noise (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .set(rx_take & rx_frame.noise),
      .clr_auto(1'b0),
      .rd_status(status_rd),
      .seen(status_seen[`UF_NOISE_BIT]),
      .data_access(data_rd),
      .flag(flags[`UF_NOISE_BIT])
   );

   // framing error, only alongside a frame that lands
   flag_cell #(.CLEAR_WINS(1'b0), .RESET_VAL(1'b0)) u_frame_err (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .set(rx_take & rx_frame.stop_bad),
      .clr_auto(1'b0),
      .rd_status(status_rd),
      .seen(status_seen[`UF_FRAME_ERR_BIT]),
      .data_access(data_rd),
      .flag(flags[`UF_FRAME_ERR_BIT])
   );

   // parity error, only when checking is on
   flag_cell #(.CLEAR_WINS(1'b0), .RESET_VAL(1'b0)) u_parity_err (
      .core_clk(core_clk),
      .rst_n(rst_sync_n),
      .set(rx_take & control.parity_check_on & parity_bad),
      .clr_auto(1'b0),
      .rd_status(status_rd),
      .seen(status_seen[`UF_PARITY_ERR_BIT]),
      .data_access(data_rd),
      .flag(flags[`UF_PARITY_ERR_BIT])
   );

   // ------------------------------------------------------------------
   // interrupt request
   // ------------------------------------------------------------------

   // each source gated by its enable; full and overrun share one
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq <= 1'b0;
      end else begin
         irq <= (flags[`UF_TX_EMPTY_BIT] & control.tx_empty_irq_en)
              | (flags[`UF_TX_DONE_BIT] & control.tx_done_irq_en)
              | ((flags[`UF_RX_FULL_BIT] | flags[`UF_OVERRUN_BIT])
                 & control.receive_int_en)
              | (flags[`UF_IDLE_BIT] & control.line_quiet_irq_en);
      end
   end

endmodule

// ### dv/uart_status_flags_one_asserts.sv
// port checker for the status flag block
// assumes one clock domain and a bind to the top module
`include "uart_flags_regs.svh"

module uart_flags_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire uart_flags_pkg::rx_event_t rx_frame,
   input wire logic rx_frame_valid,
   input wire logic rx_accept,
   input wire logic tx_load,
   input wire logic [7:0] tx_byte,
   input wire logic tx_full
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // completed bus transfers by kind
   logic acc, wr_data, rd_data, wr_stat, rd_stat;
   assign acc = psel && penable;
   assign wr_data = acc && pwrite && paddr == `UF_DATA_LOW_OFFSET;
   assign rd_data = acc && !pwrite && paddr == `UF_DATA_LOW_OFFSET;
   assign wr_stat = acc && pwrite && paddr == `UF_STATUS_OFFSET;
   assign rd_stat = acc && !pwrite && paddr == `UF_STATUS_OFFSET;

   property p_load_empty;
      tx_load |=> !tx_full;
   endproperty
   a_load_empty: assert property (p_load_empty) else $error("empty not set by load");
   property p_full_rise;
      $rose(tx_full) |-> $past(wr_data);
   endproperty
   a_full_rise: assert property (p_full_rise) else $error("empty cleared without write");
   property p_byte;
      wr_data |=> tx_byte == $past(pwdata[7:0]);
   endproperty
   a_byte: assert property (p_byte) else $error("data byte not taken");
   property p_stop_fall;
      $fell(rx_accept) |-> $past(rx_frame_valid && rx_frame.stop_bad);
   endproperty
   a_stop_fall: assert property (p_stop_fall) else $error("blocked without bad stop");
   property p_stop_rise;
      $rose(rx_accept) |-> $past(rd_data);
   endproperty
   a_stop_rise: assert property (p_stop_rise) else $error("unblocked without data read");
   property p_stat_wr;
      wr_stat && !tx_load && !rx_frame_valid |=> $stable(tx_full) && $stable(rx_accept);
   endproperty
   a_stat_wr: assert property (p_stat_wr) else $error("status write changed flags");
   property p_empty_rd;
      rd_stat |-> prdata[`UF_TX_EMPTY_BIT] == !$past(tx_full);
   endproperty
   a_empty_rd: assert property (p_empty_rd) else $error("empty readback wrong");
   property p_stop_rd;
      rd_stat |-> prdata[`UF_FRAME_ERR_BIT] == !$past(rx_accept);
   endproperty
   a_stop_rd: assert property (p_stop_rd) else $error("framing readback wrong");
   // main scenarios reached
   c_frame: cover property (rx_frame_valid);
   c_load: cover property (tx_load);
   c_block: cover property ($fell(rx_accept));
endmodule

bind uart_status_flags_one uart_flags_checker chk (.core_clk(core_clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .rx_frame(rx_frame), .rx_frame_valid(rx_frame_valid),
   .rx_accept(rx_accept), .tx_load(tx_load), .tx_byte(tx_byte), .tx_full(tx_full));

// ### dv/serial_far_end.sv
// far-side model: receive shifter, baud ticks, transmit shifter
// assumes the bench calls its tasks from one process
module serial_far_end (
   input wire logic core_clk,
   output logic rx_line,
   output logic bit_tick,
   output uart_flags_pkg::rx_event_t rx_frame,
   output logic rx_frame_valid,
   output logic tx_load,
   output logic tx_busy,
   output logic tx_queued
);
   // idle line and quiet shifters at time zero
   initial begin
      rx_line = 1'b1;
      bit_tick = 1'b0;
      rx_frame = '0;
      rx_frame_valid = 1'b0;
      tx_load = 1'b0;
      tx_busy = 1'b0;
      tx_queued = 1'b0;
   end
   // start bit, then a finished frame handed over
   task automatic frame(input logic [7:0] d, input logic nz, sb, par);
      @(posedge core_clk) rx_line <= 1'b0;
      repeat (3) @(posedge core_clk);
      bit_tick <= 1'b1;
      @(posedge core_clk);
      bit_tick <= 1'b0;
      rx_line <= 1'b1;
      rx_frame <= '{d, 1'b0, par, nz, sb};
      rx_frame_valid <= 1'b1;
      @(posedge core_clk);
      rx_frame_valid <= 1'b0;
      rx_frame <= ~rx_frame; // stale once valid drops
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge core_clk) bit_tick <= 1'b1;
         @(posedge core_clk) bit_tick <= 1'b0;
      end
   endtask
   // a short space on the line with no frame handed over
   task automatic space(input int n);
      @(posedge core_clk) rx_line <= 1'b0;
      repeat (n) @(posedge core_clk);
      rx_line <= 1'b1;
   endtask
   task automatic load();
      @(posedge core_clk) tx_load <= 1'b1;
      @(posedge core_clk) tx_load <= 1'b0;
   endtask
   task automatic tx_state(input logic b, q);
      @(posedge core_clk);
      tx_busy <= b;
      tx_queued <= q;
   endtask
endmodule

// ### dv/tb_uart_status_flags_one.sv
// self-checking bench for the status flag block
// assumes far-side model and checker compiled before it
module tb_uart_status_flags_one;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] stat_a = 8'h04;
   localparam logic [7:0] ctl_a = 8'h08;
   localparam logic [7:0] dat_a = 8'h0c;
   logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, perr;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd_val;
   logic pready, pslverr, rx_line, bit_tick, rx_frame_valid, rx_accept;
   logic tx_load, tx_busy, tx_queued, tx_full, irq;
   logic [7:0] tx_byte;
   uart_flags_pkg::rx_event_t rx_frame;
   int error_cnt = 0, checked = 0, cyc = 0;

   uart_status_flags_one uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_line(rx_line), .bit_tick(bit_tick),
      .rx_frame(rx_frame), .rx_frame_valid(rx_frame_valid), .rx_accept(rx_accept),
      .tx_load(tx_load), .tx_busy(tx_busy), .tx_queued(tx_queued), .tx_byte(tx_byte),
      .tx_full(tx_full), .irq(irq));
   serial_far_end far (.core_clk(core_clk), .rx_line(rx_line), .bit_tick(bit_tick),
      .rx_frame(rx_frame), .rx_frame_valid(rx_frame_valid), .tx_load(tx_load),
      .tx_busy(tx_busy), .tx_queued(tx_queued));

   // 200 MHz clock and run limit
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (error_cnt == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // one apb transfer, held until pready
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd_val = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      repeat (2) @(posedge core_clk);
      acc(1'b0, a, 0);
      chk(nm, e, rd_val);
   endtask

   task automatic t_tx();
      acc(1'b1, dat_a, 8'h5a);
      rd(stat_a, 8'hc0, "empty unarmed");
      acc(1'b1, dat_a, 8'ha5);
      rd(stat_a, 8'h00, "empty cleared");
      chk("byte", 8'ha5, tx_byte);
      chk("tx_full", 1, tx_full);
      far.tx_state(1'b1, 1'b0);
      far.load();
      rd(stat_a, 8'h80, "busy");
      far.tx_state(1'b0, 1'b1);
      rd(stat_a, 8'h80, "queued");
      far.tx_state(1'b0, 1'b0);
      rd(stat_a, 8'hc0, "done");
   endtask
   task automatic t_regs();
      acc(1'b1, stat_a, 32'h0000_0000);
      rd(stat_a, 8'hc0, "status write");
      acc(1'b0, 8'h20, 0);
      chk("slverr", 1, perr);
   endtask
   task automatic t_rx();
      far.frame(8'h3c, 1'b1, 1'b0, 1'b0);
      rd(stat_a, 8'he4, "full noise");
      far.frame(8'h55, 1'b0, 1'b1, 1'b0);
      rd(dat_a, 8'h3c, "kept data");
      rd(stat_a, 8'hc8, "overrun left");
      acc(1'b0, dat_a, 0);
      rd(stat_a, 8'hc0, "overrun gone");
   endtask
   task automatic t_frame_err();
      far.frame(8'h81, 1'b0, 1'b1, 1'b0);
      rd(stat_a, 8'he2, "frame err");
      chk("blocked", 0, rx_accept);
      far.frame(8'h18, 1'b0, 1'b0, 1'b0);
      rd(stat_a, 8'he2, "dropped");
      rd(dat_a, 8'h81, "frame data");
      rd(stat_a, 8'hc0, "frame gone");
      chk("open", 1, rx_accept);
   endtask
   // even and odd parity, good and bad
   task automatic t_parity();
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, ctl_a, {29'h0, 1'b1, i[1], 1'b0});
         far.frame(8'h07, 1'b0, 1'b0, ^8'h07 ^ i[1] ^ !i[0]);
         rd(stat_a, {7'h70, !i[0]}, "parity");
         acc(1'b0, dat_a, 0);
      end
      acc(1'b1, ctl_a, 0);
   endtask
   task automatic t_idle(input logic [7:0] ctl, input int run, input logic [31:0] e);
      acc(1'b1, ctl_a, ctl);
      far.frame(8'h42, 1'b0, 1'b0, 1'b0);
      acc(1'b0, stat_a, 0);
      acc(1'b0, dat_a, 0);
      far.ticks(run - 1);
      rd(stat_a, 8'hc0, "idle early");
      far.ticks(1);
      rd(stat_a, e, "idle run");
      acc(1'b0, dat_a, 0);
      rd(stat_a, 8'hc0, "idle clear");
      far.space(3);
      far.ticks(12);
      rd(stat_a, 8'hc0, "idle rearm");
   endtask
   task automatic t_irq();
      acc(1'b1, ctl_a, 8'h20);
      far.frame(8'h11, 1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge core_clk);
      chk("irq on", 1, irq);
      rd(ctl_a, 8'h20, "control");
      acc(1'b1, ctl_a, 8'h00);
      repeat (3) @(posedge core_clk);
      chk("irq off", 0, irq);
      acc(1'b1, ctl_a, 8'h80);
      repeat (3) @(posedge core_clk);
      chk("irq empty", 1, irq);
   endtask

   // reset, then every scenario in turn
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_tx();
      t_regs();
      t_rx();
      t_frame_err();
      t_parity();
      t_idle(8'h00, 10, 8'hd0);
      t_idle(8'h08, 11, 8'hd0);
      t_idle(8'h01, 12, 8'hc0);
      t_irq();
      print_verdict();
   end
endmodule
